// [rtl/pwm_timer_pkg.sv]
// constants and carrier types of the pwm clock and channel timer block
// Overview of operation
// - clock a and clock b are the bus clock divided by 1 to 128, three-bit select each
// - freeze stop enable plus active freeze signal halts the prescaler input
// - prescaler input can be gated off while every channel is disabled
// - scaled clock is an 8-bit reloading down counter pulsing at one, then halved
// - scale value zero counts as 256, giving base clock divided by 512
// - writing a scale register reloads its down counter at once
// - each channel picks a, scaled a, b or scaled b with two select bits
// - after reset channels 0,1,4,5 use clock a and 2,3,6,7 clock b
// - each channel has 8-bit counter, period and duty; period match sets the period
// - duty match sets the channel output flip-flop when left aligned, toggles it when center aligned
// - enable drives the output at once; counting starts at the second clock tick after it
// - channel clock gated only at a tick; disabled counter holds its value
// - polarity set starts high then low at duty; clear starts low then high
// - while enabled, period and duty writes wait in buffers until period end or reload
// - while disabled, period and duty writes reach buffer and active value together
// - counter write clears it and loads buffered period and duty at once
// - pair select 0 picks a side for channels 0,1, b side for 2,3
// - counter write also forces counting up and output to the polarity level, unless left aligned with duty zero
// - left aligned counts 0 to period-1; period match resets and reloads
// - center aligned counts up to period and down to zero, reloading at zero
package pwm_timer_pkg;
  localparam int NUM_CH = 8;
  localparam logic [2:0] RG_GLOBAL = 3'h0;
  localparam logic [2:0] RG_SCALE = 3'h1;
  localparam logic [2:0] RG_COUNTER = 3'h2;
  localparam logic [2:0] RG_PERIOD = 3'h3;
  localparam logic [2:0] RG_DUTY = 3'h4;
  localparam logic [2:0] IX_ENABLE = 3'h0;
  localparam logic [2:0] IX_POLARITY = 3'h1;
  localparam logic [2:0] IX_SCALED_SEL = 3'h2;
  localparam logic [2:0] IX_PAIR_SEL = 3'h3;
  localparam logic [2:0] IX_CENTER = 3'h4;
  localparam logic [2:0] IX_PRESCALE = 3'h5;
  localparam logic [2:0] IX_CONTROL = 3'h6;
  localparam logic [2:0] IX_STATUS = 3'h7;
  localparam logic [2:0] IX_SCALE_A = 3'h0;
  localparam logic [2:0] IX_SCALE_B = 3'h1;
  localparam int BIT_FREEZE_STOP = 0;
  localparam int BIT_IDLE_GATE = 1;
  localparam int PRE_A_LSB = 0;
  localparam int PRE_B_LSB = 4;
  localparam logic [7:0] RST_REG8 = 8'h00;
  localparam logic [1:0] RST_CONTROL = 2'h0;
  localparam logic [6:0] RST_PRESCALE_CNT = 7'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic en;
    logic pol;
    logic cae;
  } chan_cfg_t;

  typedef struct packed {
    logic cnt_wr;
    logic per_wr;
    logic duty_wr;
    logic [7:0] data;
  } chan_wr_t;

  typedef enum {RD_IDLE, RD_DATA} rd_state_t;
endpackage

// [rtl/pwm_scaler.sv]
// reloadable scale divider producing a scaled clock enable
`timescale 1ns/10ps
`default_nettype none
module pwm_scaler
  import pwm_timer_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_tick,
  input wire logic i_load,
  input wire logic [7:0] i_scale,
  output logic o_tick
);
  logic [7:0] cnt_reg;
  logic half_reg;
  logic tick_reg;
  wire at_one = (cnt_reg == 8'h01);
  wire pulse = i_tick && at_one;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_reg <= RST_REG8;
      half_reg <= 1'b0;
      tick_reg <= 1'b0;
    end else if (i_load) begin
      cnt_reg <= i_scale;
      half_reg <= 1'b0;
      tick_reg <= 1'b0;
    end else begin
      if (i_tick) begin
        cnt_reg <= at_one ? i_scale : cnt_reg - 8'h01;
      end
      if (pulse) begin
        half_reg <= ~half_reg;
      end
      tick_reg <= pulse && half_reg;
    end
  end

  assign o_tick = tick_reg;

  reload_at_one_a: assert property (@(posedge i_clk) disable iff (i_rst)
    pulse && !i_load |=> cnt_reg == $past(i_scale) && o_tick == $past(half_reg))
    else $error("scale counter did not reload at one");
  load_on_write_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_load |=> cnt_reg == $past(i_scale) && !o_tick)
    else $error("scale write did not reload counter");
endmodule
`default_nettype wire

// [rtl/pwm_channel.sv]
// one pwm channel timer with double-buffered period and duty
`timescale 1ns/10ps
`default_nettype none
module pwm_channel
  import pwm_timer_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_tick,
  input wire chan_cfg_t i_cfg,
  input wire chan_wr_t i_wr,
  output logic o_pwm,
  output logic [7:0] o_cnt,
  output logic [7:0] o_per,
  output logic [7:0] o_duty
);
  logic run_reg, up_reg, q_reg, pwm_reg, up_next, q_next;
  logic [7:0] cnt_reg, per_buf_reg, duty_buf_reg, per_act_reg, duty_act_reg, cnt_next;
  wire step = i_tick && run_reg && i_cfg.en;
  wire [8:0] cnt_inc = {1'b0, cnt_reg} + 9'h001;
  wire left_wrap = (cnt_inc >= {1'b0, per_act_reg});
  wire top_turn = up_reg && (cnt_reg >= per_act_reg) && (cnt_reg != 8'h00);
  wire bot_turn = !up_reg && (cnt_reg <= 8'h01);
  wire [7:0] per_new = i_wr.per_wr ? i_wr.data : per_buf_reg;
  wire [7:0] duty_new = i_wr.duty_wr ? i_wr.data : duty_buf_reg;
  wire reload = i_wr.cnt_wr || !i_cfg.en || (step && (i_cfg.cae ? bot_turn : left_wrap));

  always_comb begin
    cnt_next = cnt_reg;
    up_next = up_reg;
    q_next = q_reg;
    if (i_wr.cnt_wr) begin
      cnt_next = 8'h00;
      up_next = 1'b1;
      q_next = !i_cfg.cae && (duty_new == 8'h00);
    end else if (step && !i_cfg.cae) begin
      if (left_wrap) begin
        cnt_next = 8'h00;
        q_next = (duty_new == 8'h00);
      end else begin
        cnt_next = cnt_inc[7:0];
        q_next = q_reg | (cnt_inc[7:0] == duty_act_reg);
      end
    end else if (step) begin
      if (top_turn) begin
        cnt_next = cnt_reg - 8'h01;
        up_next = 1'b0;
        q_next = q_reg ^ (cnt_next == duty_act_reg);
      end else if (bot_turn) begin
        cnt_next = 8'h00;
        up_next = 1'b1;
        q_next = 1'b0;
      end else if (up_reg && per_act_reg != 8'h00) begin
        cnt_next = cnt_inc[7:0];
        q_next = q_reg ^ (cnt_inc[7:0] == duty_act_reg);
      end else if (!up_reg) begin
        cnt_next = cnt_reg - 8'h01;
        q_next = q_reg ^ (cnt_next == duty_act_reg);
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      run_reg <= 1'b0;
      up_reg <= 1'b1;
      q_reg <= 1'b0;
      pwm_reg <= 1'b0;
      cnt_reg <= RST_REG8;
      per_buf_reg <= RST_REG8;
      duty_buf_reg <= RST_REG8;
      per_act_reg <= RST_REG8;
      duty_act_reg <= RST_REG8;
    end else begin
      if (i_tick) begin
        run_reg <= i_cfg.en;
      end
      up_reg <= up_next;
      q_reg <= q_next;
      pwm_reg <= i_cfg.en && (i_cfg.pol ? !q_next : q_next);
      cnt_reg <= cnt_next;
      per_buf_reg <= per_new;
      duty_buf_reg <= duty_new;
      per_act_reg <= reload ? per_new : per_act_reg;
      duty_act_reg <= reload ? duty_new : duty_act_reg;
    end
  end

  assign o_pwm = pwm_reg;
  assign o_cnt = cnt_reg;
  assign o_per = per_buf_reg;
  assign o_duty = duty_buf_reg;

  hold_disabled_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_cfg.en && !i_wr.cnt_wr |=> cnt_reg == $past(cnt_reg))
    else $error("disabled counter moved");
  counter_clear_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_wr.cnt_wr |=> cnt_reg == 8'h00 && up_reg && per_act_reg == $past(per_new))
    else $error("counter write did not clear and load");
  buffer_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_cfg.en && i_wr.per_wr && !i_wr.cnt_wr && !(step && (i_cfg.cae ? bot_turn : left_wrap))
    |=> per_act_reg == $past(per_act_reg))
    else $error("period took effect while enabled");
  direct_load_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_cfg.en && i_wr.duty_wr |=> duty_act_reg == $past(i_wr.data) && o_duty == duty_act_reg)
    else $error("disabled duty write missed active value");
endmodule
`default_nettype wire

// [rtl/pwm_timer_top.sv]
// pwm clock tree, channel timers and axi4-lite register slave
//
// The AXI4-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module pwm_timer_top
  import pwm_timer_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [7:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [7:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  input wire logic i_freeze,
  output logic [7:0] o_pwm
);
  // software registers
  logic [7:0] enable_reg;
  logic [7:0] polarity_reg;
  logic [7:0] scaled_select_reg;
  logic [7:0] pair_select_reg;
  logic [7:0] center_align_reg;
  logic [7:0] prescale_select_reg;
  logic [1:0] pwm_control_reg;
  logic [7:0] scale_a_value;
  logic [7:0] scale_b_value;

  // write channel state
  logic awready_reg;
  logic wready_reg;
  logic aw_full_reg;
  logic w_full_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic [7:0] waddr_reg;
  logic [7:0] wdata_reg;
  logic wbyte_reg;

  // read channel state
  rd_state_t rd_state_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic [7:0] rd_word;
  logic rd_ok;

  // clock tree
  logic [1:0] freeze_sync_reg;
  logic [6:0] pre_cnt_reg;
  logic ce_sa;
  logic ce_sb;

  // channel side
  logic [7:0] ch_tick;
  logic [7:0] ch_pwm;
  logic [7:0] ch_cnt [NUM_CH];
  logic [7:0] ch_per [NUM_CH];
  logic [7:0] ch_duty [NUM_CH];
  chan_wr_t ch_wr [NUM_CH];

  // write handshake
  wire aw_take = i_awvalid && awready_reg;
  wire w_take = i_wvalid && wready_reg;
  wire do_wr = aw_full_reg && w_full_reg && !bvalid_reg;
  wire aw_full_next = (aw_full_reg || aw_take) && !do_wr;
  wire w_full_next = (w_full_reg || w_take) && !do_wr;
  wire b_done = bvalid_reg && i_bready;

  // write decode
  wire [2:0] w_rg = waddr_reg[7:5];
  wire [2:0] w_ix = waddr_reg[4:2];
  wire wr_en = do_wr && wbyte_reg;
  wire wr_glob = wr_en && (w_rg == RG_GLOBAL);
  wire wr_enable = wr_glob && (w_ix == IX_ENABLE);
  wire wr_polarity = wr_glob && (w_ix == IX_POLARITY);
  wire wr_scaled_sel = wr_glob && (w_ix == IX_SCALED_SEL);
  wire wr_pair_sel = wr_glob && (w_ix == IX_PAIR_SEL);
  wire wr_center = wr_glob && (w_ix == IX_CENTER);
  wire wr_prescale = wr_glob && (w_ix == IX_PRESCALE);
  wire wr_control = wr_glob && (w_ix == IX_CONTROL);
  wire wr_scale_a = wr_en && (w_rg == RG_SCALE) && (w_ix == IX_SCALE_A);
  wire wr_scale_b = wr_en && (w_rg == RG_SCALE) && (w_ix == IX_SCALE_B);
  wire w_mapped = (w_rg == RG_GLOBAL)
    || ((w_rg == RG_SCALE) && (w_ix <= IX_SCALE_B))
    || ((w_rg >= RG_COUNTER) && (w_rg <= RG_DUTY));

  // read decode
  wire ar_take = i_arvalid && arready_reg;
  wire [2:0] r_rg = i_araddr[7:5];
  wire [2:0] r_ix = i_araddr[4:2];

  // prescaler gating and divided clock enables
  wire frozen = pwm_control_reg[BIT_FREEZE_STOP] && freeze_sync_reg[1];
  wire idle_off = pwm_control_reg[BIT_IDLE_GATE] && (enable_reg == 8'h00);
  wire pre_run = !frozen && !idle_off;
  wire [2:0] clock_a_divide_sel = prescale_select_reg[PRE_A_LSB +: 3];
  wire [2:0] clock_b_divide_sel = prescale_select_reg[PRE_B_LSB +: 3];
  wire [7:0] span_a = (8'h01 << clock_a_divide_sel) - 8'h01;
  wire [7:0] span_b = (8'h01 << clock_b_divide_sel) - 8'h01;
  wire ce_a = pre_run && ((pre_cnt_reg & span_a[6:0]) == span_a[6:0]);
  wire ce_b = pre_run && ((pre_cnt_reg & span_b[6:0]) == span_b[6:0]);
  wire [7:0] scale_a_load = wr_scale_a ? wdata_reg : scale_a_value;
  wire [7:0] scale_b_load = wr_scale_b ? wdata_reg : scale_b_value;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      freeze_sync_reg <= 2'h0;
      pre_cnt_reg <= RST_PRESCALE_CNT;
    end else begin
      freeze_sync_reg <= {freeze_sync_reg[0], i_freeze};
      if (pre_run) begin
        pre_cnt_reg <= pre_cnt_reg + 7'h01;
      end
    end
  end

  pwm_scaler scaler_a (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_tick(ce_a),
    .i_load(wr_scale_a),
    .i_scale(scale_a_load),
    .o_tick(ce_sa)
  );

  pwm_scaler scaler_b (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_tick(ce_b),
    .i_load(wr_scale_b),
    .i_scale(scale_b_load),
    .o_tick(ce_sb)
  );

  // per-channel clock select and timers
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    localparam logic FLIP_AB = 1'((i / 2) % 2);
    wire use_b = pair_select_reg[i] ^ FLIP_AB;
    wire tick_a = scaled_select_reg[i] ? ce_sa : ce_a;
    wire tick_b = scaled_select_reg[i] ? ce_sb : ce_b;
    wire chan_cfg_t cfg = '{en: enable_reg[i], pol: polarity_reg[i], cae: center_align_reg[i]};
    assign ch_tick[i] = use_b ? tick_b : tick_a;
    assign ch_wr[i].cnt_wr = wr_en && (w_rg == RG_COUNTER) && (w_ix == 3'(i));
    assign ch_wr[i].per_wr = wr_en && (w_rg == RG_PERIOD) && (w_ix == 3'(i));
    assign ch_wr[i].duty_wr = wr_en && (w_rg == RG_DUTY) && (w_ix == 3'(i));
    assign ch_wr[i].data = wdata_reg;

    pwm_channel chan (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_tick(ch_tick[i]),
      .i_cfg(cfg),
      .i_wr(ch_wr[i]),
      .o_pwm(ch_pwm[i]),
      .o_cnt(ch_cnt[i]),
      .o_per(ch_per[i]),
      .o_duty(ch_duty[i])
    );
  end

  // register file
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      enable_reg <= RST_REG8;
      polarity_reg <= RST_REG8;
      scaled_select_reg <= RST_REG8;
      pair_select_reg <= RST_REG8;
      center_align_reg <= RST_REG8;
      prescale_select_reg <= RST_REG8;
      pwm_control_reg <= RST_CONTROL;
      scale_a_value <= RST_REG8;
      scale_b_value <= RST_REG8;
    end else begin
      if (wr_enable) begin
        enable_reg <= wdata_reg;
      end
      if (wr_polarity) begin
        polarity_reg <= wdata_reg;
      end
      if (wr_scaled_sel) begin
        scaled_select_reg <= wdata_reg;
      end
      if (wr_pair_sel) begin
        pair_select_reg <= wdata_reg;
      end
      if (wr_center) begin
        center_align_reg <= wdata_reg;
      end
      if (wr_prescale) begin
        prescale_select_reg <= {1'b0, wdata_reg[6:4], 1'b0, wdata_reg[2:0]};
      end
      if (wr_control) begin
        pwm_control_reg <= wdata_reg[1:0];
      end
      if (wr_scale_a) begin
        scale_a_value <= wdata_reg;
      end
      if (wr_scale_b) begin
        scale_b_value <= wdata_reg;
      end
    end
  end

  // write channel
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      waddr_reg <= RST_REG8;
      wdata_reg <= RST_REG8;
      wbyte_reg <= 1'b0;
    end else begin
      aw_full_reg <= aw_full_next;
      w_full_reg <= w_full_next;
      awready_reg <= !aw_full_next;
      wready_reg <= !w_full_next;
      if (aw_take) begin
        waddr_reg <= i_awaddr;
      end
      if (w_take) begin
        wdata_reg <= i_wdata[7:0];
        wbyte_reg <= i_wstrb[0];
      end
      if (do_wr) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= w_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (b_done) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // read selection
  always_comb begin
    rd_word = RST_REG8;
    rd_ok = 1'b1;
    if (r_rg == RG_GLOBAL) begin
      if (r_ix == IX_ENABLE) begin
        rd_word = enable_reg;
      end else if (r_ix == IX_POLARITY) begin
        rd_word = polarity_reg;
      end else if (r_ix == IX_SCALED_SEL) begin
        rd_word = scaled_select_reg;
      end else if (r_ix == IX_PAIR_SEL) begin
        rd_word = pair_select_reg;
      end else if (r_ix == IX_CENTER) begin
        rd_word = center_align_reg;
      end else if (r_ix == IX_PRESCALE) begin
        rd_word = prescale_select_reg;
      end else if (r_ix == IX_CONTROL) begin
        rd_word = {6'h00, pwm_control_reg};
      end else begin
        rd_word = ch_pwm;
      end
    end else if ((r_rg == RG_SCALE) && (r_ix == IX_SCALE_A)) begin
      rd_word = scale_a_value;
    end else if ((r_rg == RG_SCALE) && (r_ix == IX_SCALE_B)) begin
      rd_word = scale_b_value;
    end else if (r_rg == RG_COUNTER) begin
      rd_word = ch_cnt[r_ix];
    end else if (r_rg == RG_PERIOD) begin
      rd_word = ch_per[r_ix];
    end else if (r_rg == RG_DUTY) begin
      rd_word = ch_duty[r_ix];
    end else begin
      rd_ok = 1'b0;
    end
  end

  // read channel
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rd_state_reg <= RD_IDLE;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= RESP_OKAY;
    end else begin
      case (rd_state_reg)
        RD_IDLE: begin
          arready_reg <= 1'b1;
          if (ar_take) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rdata_reg <= {24'h00_0000, rd_word};
            rresp_reg <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            rd_state_reg <= RD_DATA;
          end
        end
        RD_DATA: begin
          if (i_rready) begin
            rvalid_reg <= 1'b0;
            arready_reg <= 1'b1;
            rd_state_reg <= RD_IDLE;
          end
        end
        default: begin
          rd_state_reg <= RD_IDLE;
        end
      endcase
    end
  end

  assign o_awready = awready_reg;
  assign o_wready = wready_reg;
  assign o_bvalid = bvalid_reg;
  assign o_bresp = bresp_reg;
  assign o_arready = arready_reg;
  assign o_rvalid = rvalid_reg;
  assign o_rdata = rdata_reg;
  assign o_rresp = rresp_reg;
  assign o_pwm = ch_pwm;

  sequence frozen_two_s;
    (pwm_control_reg[BIT_FREEZE_STOP] && freeze_sync_reg[1]) [*2];
  endsequence

  freeze_stop_a: assert property (@(posedge i_clk) disable iff (i_rst)
    frozen_two_s |-> !ce_a && !ce_b && pre_cnt_reg == $past(pre_cnt_reg))
    else $error("prescaler ran while frozen");
  idle_gate_a: assert property (@(posedge i_clk) disable iff (i_rst)
    idle_off |=> pre_cnt_reg == $past(pre_cnt_reg) || $past(wr_enable))
    else $error("prescaler ran with all channels idle");
  divide_gap_a: assert property (@(posedge i_clk) disable iff (i_rst)
    ce_a && clock_a_divide_sel != 3'h0 && !wr_prescale |=> !ce_a)
    else $error("divided clock a pulsed twice in a row");
  reset_select_a: assert property (@(posedge i_clk)
    $past(i_rst) |-> ch_tick[0] == ce_a && ch_tick[4] == ce_a && ch_tick[2] == ce_b
      && ch_tick[7] == ce_b)
    else $error("reset clock selection wrong");
  polarity_start_a: assert property (@(posedge i_clk) disable iff (i_rst)
    ch_wr[0].cnt_wr && enable_reg[0] && center_align_reg[0] |=> o_pwm[0] == polarity_reg[0])
    else $error("counter write did not set polarity level");

  sequence write_issue_s;
    do_wr ##1 bvalid_reg;
  endsequence

  write_resp_a: assert property (@(posedge i_clk) disable iff (i_rst)
    do_wr |-> write_issue_s)
    else $error("write response missing");
endmodule
`default_nettype wire

// [dv/pwm_load_model.sv]
// load model counting high samples and rising edges on one pwm pin
`timescale 1ns/10ps
`default_nettype none
module pwm_load_model (
  input wire logic i_clk,
  input wire logic i_clr,
  input wire logic [2:0] i_sel,
  input wire logic [7:0] i_pins,
  output logic [7:0] o_highs,
  output logic [7:0] o_rises
);
  logic prev_reg;
  always_ff @(posedge i_clk) begin
    prev_reg <= i_pins[i_sel];
    if (i_clr) begin
      o_highs <= 8'h00;
      o_rises <= 8'h00;
    end else begin
      o_highs <= o_highs + {7'h00, i_pins[i_sel]};
      o_rises <= o_rises + {7'h00, i_pins[i_sel] & ~prev_reg};
    end
  end
endmodule
`default_nettype wire

// [dv/pwm_clock_and_channel_timers_tb.sv]
// testbench for the pwm clock tree and channel timers
`timescale 1ns/10ps
`default_nettype none
module pwm_clock_and_channel_timers_tb
  import pwm_timer_pkg::*;
;
  logic clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, freeze, clr;
  logic [7:0] awaddr, araddr, pwm, highs, rises;
  logic [2:0] sel;
  logic [31:0] wdata, rdata, rd_val, rd2;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rd_resp;
  int n_errors, n_tests;

  pwm_timer_top uut (.i_clk(clk), .i_rst(rst), .i_awvalid(awvalid), .o_awready(awready),
    .i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata),
    .i_wstrb(wstrb), .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
    .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr), .o_rvalid(rvalid),
    .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp), .i_freeze(freeze), .o_pwm(pwm));
  pwm_load_model load (.i_clk(clk), .i_clr(clr), .i_sel(sel), .i_pins(pwm),
    .o_highs(highs), .o_rises(rises));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task summarize;
    $display("errors=%0d tests=%0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clk);
      if (!aw_done && awready) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (!bvalid) @(posedge clk);
  endtask

  task rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    @(posedge clk);
    while (!arready) @(posedge clk);
    arvalid <= 1'b0;
    @(posedge clk);
    while (!rvalid) @(posedge clk);
    rd_val = rdata;
    rd_resp = rresp;
  endtask

  task meas(input logic [2:0] ch, input logic [7:0] h, input logic [7:0] r);
    sel <= ch;
    clr <= 1'b1;
    repeat (20) @(posedge clk);
    clr <= 1'b0;
    repeat (48) @(posedge clk);
    @(negedge clk);
    if (h !== 8'hFF)
      chk({24'h000000, highs}, {24'h000000, h});
    chk({24'h000000, rises}, {24'h000000, r});
    @(posedge clk);
  endtask

  // period 4, duty 1 on one channel, measured over 48 cycles
  task run(input logic [2:0] ch, input logic pol, input logic cae, input logic scl,
    input logic [7:0] pre, input logic [7:0] scale, input logic [7:0] pair,
    input logic [7:0] h, input logic [7:0] r);
    logic [7:0] m;
    m = 8'h01 << ch;
    wr(8'h00, 8'h00);
    wr(8'h04, pol ? m : 8'h00);
    wr(8'h08, scl ? m : 8'h00);
    wr(8'h0C, pair);
    wr(8'h10, cae ? m : 8'h00);
    wr(8'h14, pre);
    wr(8'h20, scale);
    wr(8'h60 + {3'h0, ch, 2'h0}, 8'h04);
    wr(8'h80 + {3'h0, ch, 2'h0}, 8'h01);
    wr(8'h40 + {3'h0, ch, 2'h0}, 8'h00);
    wr(8'h00, m);
    meas(ch, h, r);
  endtask

  initial begin
    rst = 1'b1;
    awvalid = 1'b0;
    wvalid = 1'b0;
    arvalid = 1'b0;
    bready = 1'b1;
    rready = 1'b1;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h00000000;
    wstrb = 4'hF;
    freeze = 1'b0;
    clr = 1'b1;
    sel = 3'h0;
    n_errors = 0;
    n_tests = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(8'h0C);
    chk(rd_val, 32'h00000000);
    rd(8'h14);
    chk(rd_val, 32'h00000000);
    rd(8'h28);
    chk({30'h0, rd_resp}, {30'h0, RESP_SLVERR});
    run(3'h0, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00, 8'h00, 8'h24, 8'h0C);
    wr(8'h60, 8'h08);
    rd(8'h60);
    chk(rd_val, 32'h00000008);
    meas(3'h0, 8'h2A, 8'h06);
    run(3'h0, 1'b1, 1'b0, 1'b0, 8'h00, 8'h00, 8'h00, 8'h0C, 8'h0C);
    run(3'h0, 1'b0, 1'b1, 1'b0, 8'h00, 8'h00, 8'h00, 8'h24, 8'h06);
    wr(8'h40, 8'h00);
    run(3'h0, 1'b0, 1'b0, 1'b0, 8'h01, 8'h00, 8'h00, 8'h24, 8'h06);
    run(3'h0, 1'b0, 1'b0, 1'b1, 8'h00, 8'h02, 8'h00, 8'h24, 8'h03);
    run(3'h2, 1'b0, 1'b0, 1'b0, 8'h20, 8'h02, 8'h00, 8'h24, 8'h03);
    run(3'h2, 1'b0, 1'b0, 1'b0, 8'h20, 8'h02, 8'h04, 8'h24, 8'h0C);
    wr(8'h18, 8'h01);
    freeze <= 1'b1;
    meas(3'h2, 8'hFF, 8'h00);
    freeze <= 1'b0;
    wr(8'h00, 8'h00);
    wr(8'h18, 8'h02);
    rd(8'h18);
    chk(rd_val, 32'h00000002);
    meas(3'h2, 8'h00, 8'h00);
    rd(8'h48);
    rd2 = rd_val;
    repeat (5) @(posedge clk);
    rd(8'h48);
    chk(rd_val, rd2);
    wr(8'h48, 8'h55);
    rd(8'h48);
    chk(rd_val, 32'h00000000);
    summarize;
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    summarize;
  end
endmodule
`default_nettype wire
